// ==== msg_gate.sv ====
// Purpose: monitor-mode flash security gate with serial key intake
// Assumes: stored key bytes and the extended-security byte are presented by the flash
// Notes: flash array itself lives outside; this block only filters and erases by command
`timescale 1ns/1ns
// How it works
// - host sends eight bytes; compared in order with stored top-of-flash bytes
// - after power-on reset, wait for eight bytes before anything else
// - full match unlocks flash reads and execution
// - unlocked state persists until power-on reset only
// - other resets keep unlock state; unlocked they demand no new key, locked they return to idle
// - mismatch keeps monitor mode but flash reads return invalid data
// - fetch from flash while locked raises illegal-address reset
// - break is sent only after the eighth byte is received
// - status byte bit 6 shows key was correct
// - mass erase leaves all eight key bytes blank
// - zero extended-security byte refuses monitor entry
// - fail the check then mass erase to clear extended security
// - erase one 64-byte page, or whole array via block-protect address
// - break is zero start bit plus nine more zero bits
// - bit rate is clock divided by 256
// - plain NRZ framing, equal rates both ways
module msg_gate import msg_pkg::*; #(
    parameter int DIV = BIT_DIV // clocks per serial bit
) (
    input wire logic sys_clk, // 250 MHz clock
    input wire logic reset_n, // power-on reset, async active low
    input wire logic sys_reset_n, // any other reset, sync active low
    input wire logic mon_entry, // request to enter monitor mode
    input wire logic [63:0] stored_key, // bytes at fff6..fffd, fff6 in low byte
    input wire logic [7:0] ext_sec_byte, // byte at fdff
    input wire logic monitor_serial_pin_in, // serial line level
    output logic monitor_serial_pin_out, // serial drive level
    output logic monitor_serial_pin_oe, // high while driving
    input wire msg_rd_req_type rd_req, // flash read or fetch request
    input wire logic [7:0] flash_rdata, // raw flash data
    output logic [7:0] rd_data, // filtered read data
    output logic illegal_reset, // one-cycle illegal-address reset pulse
    input wire msg_erase_req_type erase_req, // erase command
    output logic erase_page, // pulse: erase 64-byte page at erase_addr
    output logic erase_mass, // pulse: erase whole array, key bytes blank
    output logic [15:0] erase_addr, // page base address
    output logic mon_refused, // monitor entry denied
    output logic unlocked, // security bypassed
    output logic cmd_ready, // monitor may take commands
    output logic [7:0] status_byte // RAM status byte, bit 6 = key ok
);
    // divider must fit div_reg and leave room for a mid-bit sample point
    if (DIV < 4 || DIV > 65535) begin : g_div_check
        $error("DIV out of range");
    end

    typedef enum {ST_IDLE, ST_RX, ST_LATCH, ST_BREAK, ST_READY, ST_REFUSE} msg_state_type;
    msg_state_type state_reg, state_next;

    logic [15:0] div_reg;
    logic [3:0] bit_cnt_reg;
    logic [3:0] byte_cnt_reg;
    logic [7:0] shift_reg;
    logic match_reg;
    logic unlocked_reg;
    logic tx_active_reg;
    logic [7:0] rd_data_reg;
    logic illegal_reg;
    logic erase_page_reg;
    logic erase_mass_reg;
    logic [15:0] erase_addr_reg;

    wire half_tick = div_reg == 16'((DIV - 1) / 2);
    wire bit_tick = div_reg == 16'(DIV - 1);
    wire rx_start = state_reg == ST_RX && bit_cnt_reg == 4'h0 && !monitor_serial_pin_in;
    wire rx_busy = bit_cnt_reg != 4'h0;
    wire sample = rx_busy && half_tick;
    // count 1 is the start bit, FRAME_BITS the stop bit; only the eight between shift in
    wire data_bit = bit_cnt_reg > 4'h1 && bit_cnt_reg < 4'(FRAME_BITS);
    wire [7:0] key_byte = stored_key[byte_cnt_reg[2:0] * 8 +: 8];
    // gated by RX so the break counter never looks like a received frame
    wire byte_done = state_reg == ST_RX && sample && bit_cnt_reg == 4'(FRAME_BITS);
    wire break_last = bit_tick && bit_cnt_reg == 4'(BREAK_BITS - 1);
    wire byte_ok = shift_reg == key_byte;
    wire last_byte = byte_cnt_reg == 4'(SEC_BYTES - 1);
    wire is_flash = rd_req.addr >= EXT_SEC_ADDR;
    wire ext_on = ext_sec_byte == EXT_SEC_ON;
    wire erase_whole = erase_req.addr == BLOCK_PROTECT_ADDR;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: if (mon_entry) state_next = ext_on ? ST_REFUSE : ST_RX;
            ST_RX: if (byte_done && last_byte) state_next = ST_LATCH;
            ST_LATCH: state_next = ST_BREAK;
            ST_BREAK: if (break_last) state_next = ST_READY;
            ST_READY: state_next = ST_READY;
            ST_REFUSE: state_next = ST_REFUSE;
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_IDLE;
        end else if (!sys_reset_n) begin
            state_reg <= unlocked_reg ? ST_READY : ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // bit timing: restarts on a start edge so sampling lands mid-bit
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_reg <= 16'h0;
        end else if (rx_start || state_reg == ST_LATCH || bit_tick) begin
            div_reg <= 16'h0;
        end else begin
            div_reg <= div_reg + 16'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h0;
        end else if (state_reg == ST_RX) begin
            if (rx_start) begin
                bit_cnt_reg <= 4'h1;
            end else if (byte_done) begin
                bit_cnt_reg <= 4'h0;
            end else if (sample) begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                if (data_bit) begin
                    shift_reg <= {monitor_serial_pin_in, shift_reg[7:1]};
                end
            end
        end else if (state_reg == ST_LATCH) begin
            bit_cnt_reg <= 4'h0;
        end else if (state_reg == ST_BREAK && bit_tick) begin
            bit_cnt_reg <= break_last ? 4'h0 : bit_cnt_reg + 4'h1;
        end
    end

    // running compare; any miss sticks until power-on reset
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            byte_cnt_reg <= 4'h0;
            match_reg <= 1'b1;
        end else if (byte_done) begin
            byte_cnt_reg <= byte_cnt_reg + 4'h1;
            match_reg <= match_reg & byte_ok;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            unlocked_reg <= 1'b0;
        end else if (state_reg == ST_LATCH && match_reg) begin
            unlocked_reg <= 1'b1;
        end
    end

    // break: ten low bit times after a latched verdict
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_active_reg <= 1'b0;
        end else begin
            // a warm reset mid-break must not leave the line pulled low
            tx_active_reg <= sys_reset_n && state_next == ST_BREAK;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_reg <= 8'h0;
            illegal_reg <= 1'b0;
        end else begin
            rd_data_reg <= (is_flash && !unlocked_reg) ? INVALID_READ : flash_rdata;
            illegal_reg <= rd_req.valid && rd_req.fetch && is_flash && !unlocked_reg;
        end
    end

    // erase pulses; locked state still permits mass erase for recovery
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            erase_page_reg <= 1'b0;
            erase_mass_reg <= 1'b0;
            erase_addr_reg <= 16'h0;
        end else begin
            erase_page_reg <= erase_req.start && !erase_whole && unlocked_reg;
            erase_mass_reg <= erase_req.start && erase_whole;
            erase_addr_reg <= erase_req.addr & ~16'(PAGE_BYTES - 1);
        end
    end

    assign monitor_serial_pin_out = 1'b0;
    assign monitor_serial_pin_oe = tx_active_reg;
    assign rd_data = rd_data_reg;
    assign illegal_reset = illegal_reg;
    assign erase_page = erase_page_reg;
    assign erase_mass = erase_mass_reg;
    assign erase_addr = erase_addr_reg;
    assign mon_refused = state_reg == ST_REFUSE;
    assign unlocked = unlocked_reg;
    assign cmd_ready = state_reg == ST_READY;
    assign status_byte = 8'(unlocked_reg) << STATUS_OK_BIT;

    sequence s_latch_miss;
        state_reg == ST_LATCH && !match_reg;
    endsequence

    a_break_not_early: assert property (@(posedge sys_clk) disable iff (!reset_n)
        monitor_serial_pin_oe |-> byte_cnt_reg == 4'(SEC_BYTES))
        else $error("break before eighth byte");
    a_unlock_sticky: assert property (@(posedge sys_clk) disable iff (!reset_n)
        unlocked |=> unlocked)
        else $error("unlock lost without power-on reset");
    a_lock_read: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (is_flash && !unlocked) |=> rd_data == INVALID_READ || unlocked)
        else $error("locked read leaked data");
    a_fetch_reset: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (rd_req.valid && rd_req.fetch && is_flash && !unlocked) |=> illegal_reset)
        else $error("locked fetch without reset");
    a_ext_refuse: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (state_reg == ST_IDLE && mon_entry && ext_on && sys_reset_n) |=> mon_refused)
        else $error("extended security ignored");
    a_refuse_quiet: assert property (@(posedge sys_clk) disable iff (!reset_n)
        mon_refused |-> !cmd_ready && !monitor_serial_pin_oe)
        else $error("refused entry still answered");
    a_status_flag: assert property (@(posedge sys_clk) disable iff (!reset_n)
        status_byte[STATUS_OK_BIT] == unlocked)
        else $error("status bit wrong");
    a_mass_erase: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (erase_req.start && erase_whole) |=> erase_mass && !erase_page)
        else $error("mass erase missed");
    a_page_locked: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (erase_req.start && !unlocked) |=> !erase_page)
        else $error("page erase while locked");
    a_miss_locked: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_latch_miss |=> !unlocked)
        else $error("bad key unlocked flash");
    a_latch_before: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $rose(cmd_ready) && $past(sys_reset_n) |-> $past(monitor_serial_pin_oe))
        else $error("commands before verdict");
endmodule : msg_gate

// ==== msg_pkg.sv ====
// Purpose: shared constants and types for the monitor security gate
// Assumes: one 250 MHz clock, bytes of the flash image arrive as a byte port
// Notes: flash offsets are device addresses of the protected array
package msg_pkg;
    localparam int SEC_BYTES = 8;
    localparam logic [15:0] SEC_FIRST_ADDR = 16'hfff6;
    localparam logic [15:0] SEC_LAST_ADDR = 16'hfffd;
    localparam logic [15:0] EXT_SEC_ADDR = 16'hfdff;
    localparam logic [7:0] EXT_SEC_ON = 8'h00;
    localparam logic [7:0] BLANK_BYTE = 8'hff;
    localparam logic [7:0] INVALID_READ = 8'had;
    localparam logic [7:0] STATUS_RAM_ADDR = 8'h40;
    localparam int STATUS_OK_BIT = 6;
    localparam int PAGE_BYTES = 64;
    localparam logic [15:0] BLOCK_PROTECT_ADDR = 16'hff7e;
    localparam int BIT_DIV = 256;
    localparam int BREAK_BITS = 10;
    localparam int FRAME_BITS = 10;

    typedef struct packed {
        logic valid;
        logic [15:0] addr;
        logic fetch;
    } msg_rd_req_type;

    typedef struct packed {
        logic start;
        logic [15:0] addr;
    } msg_erase_req_type;
endpackage : msg_pkg

// ==== msg_host_pod.sv ====
// Purpose: host debug pod model sending the eight key frames
// Assumes: line released means pulled high, bit time DIV clocks
// Notes: frames go back to back; busy drops as the last stop bit starts
`timescale 1ns/1ns
module msg_host_pod #(
    parameter int DIV = 8 // clocks per serial bit
) (
    input wire logic sys_clk, // clock
    input wire logic go, // start eight frames
    input wire logic [63:0] key, // byte k at bits 8k+7:8k
    output logic line, // 0 pulls low, 1 releases to pull-up
    output logic busy // frames in flight
);
    initial begin
        line = 1'b1;
        busy = 1'b0;
    end
    always @(posedge sys_clk) begin
        if (go) begin
            busy <= 1'b1;
            for (int f = 0; f < 8; f++) begin
                for (int b = 0; b < 10; b++) begin
                    line <= (b == 0) ? 1'b0 : (b == 9) ? 1'b1 : key[8 * f + b - 1];
                    // the gate may answer from mid stop bit on, so key is done here
                    if (f == 7 && b == 9) begin
                        busy <= 1'b0;
                    end
                    repeat (DIV) @(posedge sys_clk);
                end
            end
        end
    end
endmodule : msg_host_pod

// ==== tb_top.sv ====
// Purpose: self-checking bench for the monitor security gate
// Assumes: bit time shortened to 8 clocks
// Notes: three entries per run: good key, bad key, extended lock
`timescale 1ns/1ns
module tb_top import msg_pkg::*;;
    localparam int D = 8;
    logic sys_clk = 0, reset_n = 0, sys_reset_n = 1, mon_entry = 0, go = 0;
    logic [63:0] stored_key = '0, host_key = '0, hk;
    logic [7:0] key_q[$];
    logic [7:0] ext_sec_byte = 8'hff, flash_rdata = 8'h00, d;
    msg_rd_req_type rd_req = '0;
    msg_erase_req_type erase_req = '0;
    logic line, busy, pin_out, oe, illegal_reset, erase_page, erase_mass;
    logic mon_refused, unlocked, cmd_ready, ex;
    logic [7:0] rd_data, status_byte;
    logic [15:0] erase_addr, a;
    int err_total = 0, comparisons = 0, cyc = 0, oe_cnt = 0, early = 0;
    wire pin_in = oe ? 1'b0 : line; // pull-up when nobody drives low
    msg_gate #(.DIV(D)) u_msg_gate (.sys_clk(sys_clk), .reset_n(reset_n),
        .sys_reset_n(sys_reset_n), .mon_entry(mon_entry), .stored_key(stored_key),
        .ext_sec_byte(ext_sec_byte), .monitor_serial_pin_in(pin_in),
        .monitor_serial_pin_out(pin_out), .monitor_serial_pin_oe(oe), .rd_req(rd_req),
        .flash_rdata(flash_rdata), .rd_data(rd_data), .illegal_reset(illegal_reset),
        .erase_req(erase_req), .erase_page(erase_page), .erase_mass(erase_mass),
        .erase_addr(erase_addr), .mon_refused(mon_refused), .unlocked(unlocked),
        .cmd_ready(cmd_ready), .status_byte(status_byte));
    msg_host_pod #(.DIV(D)) u_msg_host_pod (.sys_clk(sys_clk), .go(go), .key(host_key),
        .line(line), .busy(busy));
    initial forever #2 sys_clk = ~sys_clk;
    task give_verdict;
        $display("err_total=%0d comparisons=%0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    always @(posedge sys_clk) begin
        cyc++;
        if (oe) oe_cnt++;
        if (oe && busy) early++;
        if (cyc == 20000) begin
            err_total++;
            give_verdict();
        end
    end
    task check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task enter(input logic [63:0] k);
        @(posedge sys_clk);
        mon_entry <= 1'b1;
        host_key <= k;
        oe_cnt = 0;
        early = 0;
        @(posedge sys_clk);
        mon_entry <= 1'b0;
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        for (int i = 0; i < 1500 && !cmd_ready; i++) begin
            @(posedge sys_clk);
            #1;
        end
    endtask : enter
    task rd(input logic [15:0] ad, input logic f);
        @(posedge sys_clk);
        rd_req <= '{1'b1, ad, f};
        flash_rdata <= d;
        @(posedge sys_clk);
        rd_req <= '0;
        #1;
    endtask : rd
    task er(input logic [15:0] ad);
        @(posedge sys_clk);
        erase_req <= '{1'b1, ad};
        @(posedge sys_clk);
        erase_req <= '0;
        #1;
    endtask : er
    initial begin
        void'($urandom(32'h5b9f8e9c));
        for (int t = 0; t < 3; t++) begin
            @(posedge sys_clk);
            stored_key <= {$urandom, $urandom};
            ext_sec_byte <= (t == 2) ? EXT_SEC_ON : 8'h01 + 8'($urandom % 255);
            reset_n <= 1'b0;
            repeat (12) @(posedge sys_clk);
            reset_n <= 1'b1;
            d = 8'($urandom);
            if (d == INVALID_READ)
                d = ~d;
            a = 16'hfe00 | 16'($urandom % 512);
            if (a == BLOCK_PROTECT_ADDR)
                a = 16'hfe00;
            hk = (t == 1) ? stored_key ^ (64'h1 << ($urandom % 64)) : stored_key;
            // model: key bytes queued in send order, each against its stored byte
            key_q.delete();
            for (int i = 0; i < SEC_BYTES; i++)
                key_q.push_back(hk[8 * i +: 8]);
            ex = ext_sec_byte != EXT_SEC_ON;
            foreach (key_q[i])
                if (key_q[i] != stored_key[8 * i +: 8])
                    ex = 1'b0;
            enter(hk);
            check(mon_refused, t == 2);
            check(unlocked, ex);
            check(cmd_ready, t != 2);
            check(status_byte, ex ? 8'h40 : 8'h00);
            if (t != 2) begin
                check(early, 0);
                check(oe_cnt, BREAK_BITS * D);
                check(pin_out, 1'b0);
            end
            rd(SEC_FIRST_ADDR, 1'b0);
            check(rd_data, ex ? d : INVALID_READ);
            rd(EXT_SEC_ADDR, 1'b1);
            check(illegal_reset, !ex);
            er(a);
            check({erase_page, erase_page ? erase_addr : 16'h0},
                {ex, ex ? {a[15:6], 6'h00} : 16'h0});
            check(erase_mass, 1'b0);
            er(BLOCK_PROTECT_ADDR);
            check(erase_mass, 1);
            @(posedge sys_clk);
            sys_reset_n <= 1'b0;
            @(posedge sys_clk);
            sys_reset_n <= 1'b1;
            repeat (2) @(posedge sys_clk);
            #1;
            check({unlocked, cmd_ready}, {ex, ex});
        end
        give_verdict();
    end
endmodule : tb_top
